/* design/sfm_pkg.sv */
package sfm_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_RST_IMPACT = 8'h04;
	localparam logic [7:0] ADDR_SAFE_IMPACT = 8'h08;
	localparam logic [7:0] ADDR_LIMP_IMPACT = 8'h0c;
	localparam logic [7:0] ADDR_RELEASE = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_FLAGS = 8'h18;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int CFG_LIMIT_LSB = 0;
	localparam int CFG_EXT_SAFE_BIT = 2;
	localparam int CFG_INIT_DONE_BIT = 3;
	localparam int REL_RESET_BIT = 0;
	localparam int REL_SAFE_BIT = 1;
	localparam int REL_LIMP_BIT = 2;
	localparam int FLAGS_FAILSAFE_EVENT_FLAG_BIT = 8;
	localparam int NUM_FAULTS = 8;
	localparam logic [1:0] LIMIT_RST = 2'h1;
	localparam logic EXT_SAFE_RST = 1'b0;
	localparam logic [7:0] SAFE_IMPACT_RST = 8'hff;
	localparam logic [7:0] LIMP_IMPACT_RST = 8'h00;
	localparam logic [3:0] CNT_START = 4'h1;

	// counter limit per select code 0..3: 2, 6, 8, 12
	localparam logic [15:0] LIMIT_TABLE = 16'hc862;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned FS_DUR_SHORT_MS = 100;
	localparam int unsigned FS_DUR_LONG_MS = 4000;
	localparam int unsigned RST_LOW_S = 8;
	localparam int unsigned FS_SHORT_CYC = FS_DUR_SHORT_MS * (CLK_HZ / 1000);
	localparam int unsigned FS_LONG_CYC = FS_DUR_LONG_MS * (CLK_HZ / 1000);
	localparam int unsigned RST_LOW_CYC = RST_LOW_S * CLK_HZ;
	localparam int TMR_W = 30;

	// ----------------------------------------------------------------
	// device modes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_POWERUP,
		MODE_INIT,
		MODE_NORMAL,
		MODE_LOW_POWER_ON_MODE,
		MODE_LOW_POWER_OFF_MODE,
		MODE_FAILSAFE
	} sfm_mode_e;

endpackage

/* design/sfm_tmr_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface sfm_tmr_if;
	logic run;
	logic [sfm_pkg::TMR_W-1:0] limit;
	logic done;

	modport ctrl (output run, output limit, input done);
	modport timer (input run, input limit, output done);
endinterface

`default_nettype wire

/* design/sfm_timer.sv */
`timescale 1ns/1ps
`default_nettype none

// counts while run is high; done rises once limit cycles have passed
// and stays until run falls, which also clears the count
module sfm_timer (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// control
	sfm_tmr_if.timer tmr
);
	logic [sfm_pkg::TMR_W-1:0] cnt_r;
	logic done_r;

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || !tmr.run) begin
			cnt_r <= '0;
			done_r <= 1'b0;
		end else if (!done_r) begin
			cnt_r <= cnt_r + 1'b1;
			done_r <= (cnt_r + 1'b1) >= tmr.limit;
		end
	end

	assign tmr.done = done_r;
endmodule // sfm_timer

`default_nettype wire

/* design/sfm_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// three-stage synchroniser; the output follows only once the second
// and third stages agree, which rejects a single metastable sample
module sfm_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// data
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic s1_r;
			logic s2_r;
			logic s3_r;
			logic out_r;
			always_ff @(posedge ref_clk_i) begin
				if (sys_rst_i) begin
					s1_r <= 1'b0;
					s2_r <= 1'b0;
					s3_r <= 1'b0;
					out_r <= 1'b0;
				end else begin
					s1_r <= async_i[g];
					s2_r <= s1_r;
					s3_r <= s2_r;
					if (s2_r == s3_r) begin
						out_r <= s3_r;
					end
				end
			end
			assign sync_o[g] = out_r;
		end
	endgenerate
endmodule // sfm_sync

`default_nettype wire

/* design/sfm_fault_mgr.sv */
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module sfm_fault_mgr #(
	parameter int unsigned FS_SHORT_CYC = sfm_pkg::FS_SHORT_CYC,
	parameter int unsigned FS_LONG_CYC = sfm_pkg::FS_LONG_CYC,
	parameter int unsigned RST_LOW_CYC = sfm_pkg::RST_LOW_CYC
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [31:0] reg_rdata_o,
	// one-time-programmable options
	input wire logic [7:0] otp_rst_impact_i,
	input wire logic otp_rst_low_fs_en_i,
	input wire logic otp_ov_fs_en_i,
	input wire logic otp_tsd_fs_en_i,
	input wire logic otp_first_fault_fs_i,
	input wire logic failsafe_duration_option_i,
	input wire logic failsafe_to_sleep_option_i,
	input wire logic key_cycle_option_i,
	// device sequencing, same clock
	input wire logic powerup_done_i,
	input wire logic low_power_on_req_i,
	input wire logic low_power_off_req_i,
	input wire logic wake_i,
	input wire logic [7:0] fault_i,
	// pin and analog detectors, asynchronous
	input wire logic ext_reset_det_i,
	input wire logic regulator_overvoltage_i,
	input wire logic regulator_thermal_shutdown_i,
	input wire logic main_supply_lowpower_uv_i,
	input wire logic mcu_reset_fb_n_i,
	// safety outputs
	output logic mcu_reset_output_n_o,
	output logic safe_state_output_n_o,
	output logic limp_home_output_n_o,
	// supply control
	output logic regulator_en_o,
	output logic osc_20mhz_en_o,
	output logic monitor_en_o,
	output logic failsafe_o
);
	// ----------------------------------------------------------------
	// input synchronisation
	// ----------------------------------------------------------------
	logic [4:0] pins_s;
	logic ext_rst_s;
	logic ov_s;
	logic tsd_s;
	logic uvlp_s;
	logic rst_fb_n_s;

	sfm_sync #(.W(5)) u_sync (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i({mcu_reset_fb_n_i, main_supply_lowpower_uv_i,
			regulator_thermal_shutdown_i, regulator_overvoltage_i,
			ext_reset_det_i}),
		.sync_o(pins_s)
	);

	assign ext_rst_s = pins_s[0];
	assign ov_s = pins_s[1];
	assign tsd_s = pins_s[2];
	assign uvlp_s = pins_s[3];
	// feedback resets to 0 in the synchroniser; the 8 s timer is long
	// enough that the four-cycle settle never matters
	assign rst_fb_n_s = pins_s[4];

	// ----------------------------------------------------------------
	// state and configuration
	// ----------------------------------------------------------------
	sfm_pkg::sfm_mode_e mode_r;
	sfm_pkg::sfm_mode_e mode_nxt;
	logic [3:0] cnt_r;
	logic [1:0] limit_sel_r;
	logic ext_safe_r;
	logic [7:0] rst_imp_r;
	logic [7:0] safe_imp_r;
	logic [7:0] limp_imp_r;
	logic [7:0] diag_r;
	logic failsafe_event_flag_r;
	logic from_low_power_on_mode_r;
	logic ext_rst_d_r;
	logic rst_n_r;
	logic safe_n_r;
	logic limp_n_r;
	logic reg_en_r;
	logic osc_en_r;
	logic mon_en_r;
	logic fs_r;
	logic [31:0] rdata_r;

	// ----------------------------------------------------------------
	// fault evaluation
	// ----------------------------------------------------------------
	logic active;
	logic wr;
	logic [3:0] cnt_max;
	logic [3:0] cnt_inc;
	logic [7:0] hit;
	logic hit_rst;
	logic hit_safe;
	logic hit_limp;
	logic ext_evt;
	logic count_evt;
	logic fs_enter;
	logic fs_done;
	logic rst_low_done;

	assign active = (mode_r == sfm_pkg::MODE_INIT) ||
		(mode_r == sfm_pkg::MODE_NORMAL);
	assign wr = reg_we_i;
	assign cnt_max = sfm_pkg::LIMIT_TABLE[{limit_sel_r, 2'b00} +: 4];
	assign cnt_inc = (cnt_r >= cnt_max) ? cnt_max : cnt_r + 4'h1;
	assign hit = active ? fault_i : 8'h00;
	assign hit_rst = |(hit & rst_imp_r);
	assign hit_safe = |(hit & safe_imp_r);
	assign hit_limp = |(hit & limp_imp_r);
	// our own reset pulse drives the pin low too, so that is masked
	assign ext_evt = active && ext_rst_s && !ext_rst_d_r && rst_n_r;
	// faults with no reaction stay out of the count
	assign count_evt = hit_rst || hit_safe || hit_limp || ext_evt;

	assign fs_enter = (mode_r != sfm_pkg::MODE_FAILSAFE) && (
		(count_evt && cnt_inc == cnt_max) ||
		(count_evt && otp_first_fault_fs_i) ||
		(otp_rst_low_fs_en_i && rst_low_done) ||
		(otp_ov_fs_en_i && ov_s) ||
		(otp_tsd_fs_en_i && tsd_s) ||
		(uvlp_s && (mode_r == sfm_pkg::MODE_LOW_POWER_ON_MODE ||
			(mode_r == sfm_pkg::MODE_POWERUP && from_low_power_on_mode_r))));

	// ----------------------------------------------------------------
	// timers
	// ----------------------------------------------------------------
	sfm_tmr_if fs_tmr ();
	sfm_tmr_if low_tmr ();

	assign fs_tmr.run = (mode_r == sfm_pkg::MODE_FAILSAFE);
	assign fs_tmr.limit = failsafe_duration_option_i ?
		sfm_pkg::TMR_W'(FS_LONG_CYC) : sfm_pkg::TMR_W'(FS_SHORT_CYC);
	assign fs_done = fs_tmr.done;
	assign low_tmr.run = !rst_fb_n_s;
	assign low_tmr.limit = sfm_pkg::TMR_W'(RST_LOW_CYC);
	assign rst_low_done = low_tmr.done;

	sfm_timer u_fs_tmr (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.tmr(fs_tmr.timer)
	);

	sfm_timer u_low_tmr (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.tmr(low_tmr.timer)
	);

	// ----------------------------------------------------------------
	// mode machine
	// ----------------------------------------------------------------
	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			sfm_pkg::MODE_POWERUP: begin
				if (powerup_done_i) begin
					mode_nxt = sfm_pkg::MODE_INIT;
				end
			end
			sfm_pkg::MODE_INIT: begin
				if (wr && reg_addr_i == sfm_pkg::ADDR_CFG &&
					reg_wdata_i[sfm_pkg::CFG_INIT_DONE_BIT]) begin
					mode_nxt = sfm_pkg::MODE_NORMAL;
				end
			end
			sfm_pkg::MODE_NORMAL: begin
				if (low_power_off_req_i) begin
					mode_nxt = sfm_pkg::MODE_LOW_POWER_OFF_MODE;
				end else if (low_power_on_req_i) begin
					mode_nxt = sfm_pkg::MODE_LOW_POWER_ON_MODE;
				end
			end
			sfm_pkg::MODE_LOW_POWER_ON_MODE, sfm_pkg::MODE_LOW_POWER_OFF_MODE: begin
				if (wake_i) begin
					mode_nxt = sfm_pkg::MODE_POWERUP;
				end
			end
			sfm_pkg::MODE_FAILSAFE: begin
				if (fs_done) begin
					if (failsafe_to_sleep_option_i || key_cycle_option_i) begin
						mode_nxt = sfm_pkg::MODE_LOW_POWER_OFF_MODE;
					end else begin
						mode_nxt = sfm_pkg::MODE_POWERUP;
					end
				end
			end
			default: begin
				mode_nxt = sfm_pkg::MODE_POWERUP;
			end
		endcase
		if (fs_enter) begin
			mode_nxt = sfm_pkg::MODE_FAILSAFE;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			mode_r <= sfm_pkg::MODE_POWERUP;
			from_low_power_on_mode_r <= 1'b0;
			ext_rst_d_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			ext_rst_d_r <= ext_rst_s;
			if (mode_r == sfm_pkg::MODE_LOW_POWER_ON_MODE) begin
				from_low_power_on_mode_r <= 1'b1;
			end else if (mode_r != sfm_pkg::MODE_POWERUP) begin
				from_low_power_on_mode_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// fault counter
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			cnt_r <= sfm_pkg::CNT_START;
		end else if (fs_enter) begin
			cnt_r <= sfm_pkg::CNT_START;
		end else if (mode_r == sfm_pkg::MODE_LOW_POWER_ON_MODE ||
			mode_r == sfm_pkg::MODE_LOW_POWER_OFF_MODE) begin
			cnt_r <= sfm_pkg::CNT_START;
		end else if (count_evt) begin
			cnt_r <= cnt_inc;
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rst_imp_r <= otp_rst_impact_i;
		end else if (wr && reg_addr_i == sfm_pkg::ADDR_RST_IMPACT) begin
			rst_imp_r <= reg_wdata_i[7:0];
		end
	end

	// these only take writes during init, so a running system cannot
	// quietly weaken its own safe-state reactions
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			safe_imp_r <= sfm_pkg::SAFE_IMPACT_RST;
			limp_imp_r <= sfm_pkg::LIMP_IMPACT_RST;
			limit_sel_r <= sfm_pkg::LIMIT_RST;
			ext_safe_r <= sfm_pkg::EXT_SAFE_RST;
		end else if (wr && mode_r == sfm_pkg::MODE_INIT) begin
			if (reg_addr_i == sfm_pkg::ADDR_SAFE_IMPACT) begin
				safe_imp_r <= reg_wdata_i[7:0];
			end
			if (reg_addr_i == sfm_pkg::ADDR_LIMP_IMPACT) begin
				limp_imp_r <= reg_wdata_i[7:0];
			end
			if (reg_addr_i == sfm_pkg::ADDR_CFG) begin
				limit_sel_r <= reg_wdata_i[sfm_pkg::CFG_LIMIT_LSB +: 2];
				ext_safe_r <= reg_wdata_i[sfm_pkg::CFG_EXT_SAFE_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// diagnostic and event flags, write one to clear, set wins
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			diag_r <= 8'h00;
			failsafe_event_flag_r <= 1'b0;
		end else begin
			if (wr && reg_addr_i == sfm_pkg::ADDR_FLAGS) begin
				diag_r <= (diag_r & ~reg_wdata_i[7:0]) | hit;
				failsafe_event_flag_r <= (failsafe_event_flag_r &
					~reg_wdata_i[sfm_pkg::FLAGS_FAILSAFE_EVENT_FLAG_BIT]) | fs_enter;
			end else begin
				diag_r <= diag_r | hit;
				failsafe_event_flag_r <= failsafe_event_flag_r | fs_enter;
			end
		end
	end

	// ----------------------------------------------------------------
	// safety outputs, each independent of the mode machine's next state
	// ----------------------------------------------------------------
	logic rel_wr;
	assign rel_wr = wr && reg_addr_i == sfm_pkg::ADDR_RELEASE &&
		mode_r == sfm_pkg::MODE_NORMAL;

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rst_n_r <= 1'b0;
		end else if (fs_enter || hit_rst || mode_r != sfm_pkg::MODE_NORMAL &&
			mode_r != sfm_pkg::MODE_INIT && mode_r != sfm_pkg::MODE_LOW_POWER_ON_MODE) begin
			rst_n_r <= 1'b0;
		end else if (rel_wr && reg_wdata_i[sfm_pkg::REL_RESET_BIT]) begin
			rst_n_r <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			safe_n_r <= 1'b0;
		end else if (fs_enter || hit_safe || (ext_evt && ext_safe_r) ||
			mode_r != sfm_pkg::MODE_NORMAL) begin
			safe_n_r <= 1'b0;
		end else if (rel_wr && reg_wdata_i[sfm_pkg::REL_SAFE_BIT]) begin
			safe_n_r <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			limp_n_r <= 1'b1;
		end else if (fs_enter || hit_limp ||
			mode_r == sfm_pkg::MODE_FAILSAFE) begin
			limp_n_r <= 1'b0;
		end else if (rel_wr && reg_wdata_i[sfm_pkg::REL_LIMP_BIT]) begin
			limp_n_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// supply control
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			reg_en_r <= 1'b1;
			osc_en_r <= 1'b1;
			mon_en_r <= 1'b1;
			fs_r <= 1'b0;
		end else begin
			fs_r <= (mode_nxt == sfm_pkg::MODE_FAILSAFE);
			reg_en_r <= mode_nxt != sfm_pkg::MODE_FAILSAFE &&
				mode_nxt != sfm_pkg::MODE_LOW_POWER_OFF_MODE;
			osc_en_r <= mode_nxt != sfm_pkg::MODE_LOW_POWER_ON_MODE &&
				mode_nxt != sfm_pkg::MODE_LOW_POWER_OFF_MODE;
			mon_en_r <= mode_nxt != sfm_pkg::MODE_LOW_POWER_ON_MODE &&
				mode_nxt != sfm_pkg::MODE_LOW_POWER_OFF_MODE;
		end
	end

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rdata_r <= 32'h0000_0000;
		end else if (reg_re_i) begin
			case (reg_addr_i)
				sfm_pkg::ADDR_CFG: rdata_r <= {28'h0000000, 1'b0,
					ext_safe_r, limit_sel_r};
				sfm_pkg::ADDR_RST_IMPACT: rdata_r <= {24'h000000, rst_imp_r};
				sfm_pkg::ADDR_SAFE_IMPACT: rdata_r <= {24'h000000, safe_imp_r};
				sfm_pkg::ADDR_LIMP_IMPACT: rdata_r <= {24'h000000, limp_imp_r};
				sfm_pkg::ADDR_RELEASE: rdata_r <= {29'h00000000,
					limp_n_r, safe_n_r, rst_n_r};
				sfm_pkg::ADDR_STATUS: rdata_r <= {21'h000000, cnt_max,
					mode_r, cnt_r};
				sfm_pkg::ADDR_FLAGS: rdata_r <= {23'h000000, failsafe_event_flag_r, diag_r};
				default: rdata_r <= 32'h0000_0000;
			endcase
		end else begin
			rdata_r <= 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata_o = rdata_r;
	assign mcu_reset_output_n_o = rst_n_r;
	assign safe_state_output_n_o = safe_n_r;
	assign limp_home_output_n_o = limp_n_r;
	assign regulator_en_o = reg_en_r;
	assign osc_20mhz_en_o = osc_en_r;
	assign monitor_en_o = mon_en_r;
	assign failsafe_o = fs_r;

endmodule // sfm_fault_mgr

`default_nettype wire

/* sim/sfm_mcu_model.sv */
`timescale 1ns/1ps
`default_nettype none

// mcu end of the pulled-up reset line; the mcu may hold it low or
// pull it briefly as an external reset
module sfm_mcu_model (
	// device pin
	input wire logic rst_n_i,
	// scenario controls
	input wire logic hold_low_i,
	input wire logic ext_rst_i,
	// feedback to the device
	output logic fb_n_o,
	output logic ext_det_o
);
	assign fb_n_o = rst_n_i & ~hold_low_i & ~ext_rst_i;
	// a pull only counts as external while the device lets go
	assign ext_det_o = ext_rst_i & rst_n_i;
endmodule // sfm_mcu_model

`default_nettype wire

/* sim/sfm_fault_mgr_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module sfm_fault_mgr_chk #(
	parameter int unsigned FS_SHORT_CYC = 20,
	parameter int unsigned FS_LONG_CYC = 40
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// inputs of the block
	input wire logic reg_we_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic [7:0] fault_i,
	input wire logic regulator_overvoltage_i,
	input wire logic otp_ov_fs_en_i,
	input wire logic failsafe_duration_option_i,
	// outputs of the block
	input wire logic mcu_reset_output_n_o,
	input wire logic safe_state_output_n_o,
	input wire logic limp_home_output_n_o,
	input wire logic regulator_en_o,
	input wire logic osc_20mhz_en_o,
	input wire logic monitor_en_o,
	input wire logic failsafe_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	// ------
	// fail-safe dwell counter
	// ------
	logic [31:0] fs_cnt_r;
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || !failsafe_o) begin
			fs_cnt_r <= 32'h0;
		end else begin
			fs_cnt_r <= fs_cnt_r + 32'h1;
		end
	end

	// ------
	// properties
	// ------
	sequence s_ov_held;
		otp_ov_fs_en_i && $rose(regulator_overvoltage_i)
			##1 regulator_overvoltage_i [*4];
	endsequence

	AST_FS_SUPPLY: assert property (failsafe_o |-> !regulator_en_o
		&& osc_20mhz_en_o && monitor_en_o) else $error("fail-safe supplies");
	AST_FS_PINS: assert property (failsafe_o |-> !mcu_reset_output_n_o
		&& !safe_state_output_n_o && !limp_home_output_n_o)
		else $error("fail-safe pins not low");
	// one cycle of slack allowed on the dwell length
	AST_FS_DWELL: assert property ($fell(failsafe_o) |->
		fs_cnt_r >= (failsafe_duration_option_i ? FS_LONG_CYC : FS_SHORT_CYC)
		&& fs_cnt_r <= (failsafe_duration_option_i ? FS_LONG_CYC :
		FS_SHORT_CYC) + 1) else $error("fail-safe dwell length");
	AST_FS_EXIT: assert property ($fell(failsafe_o) |->
		!mcu_reset_output_n_o && !safe_state_output_n_o)
		else $error("pins released on fail-safe exit");
	AST_RST_REL: assert property ($rose(mcu_reset_output_n_o) |->
		$past(reg_we_i && reg_addr_i == sfm_pkg::ADDR_RELEASE
		&& reg_wdata_i[sfm_pkg::REL_RESET_BIT])) else $error("reset rose");
	AST_SAFE_REL: assert property ($rose(safe_state_output_n_o) |->
		$past(reg_we_i && reg_addr_i == sfm_pkg::ADDR_RELEASE
		&& reg_wdata_i[sfm_pkg::REL_SAFE_BIT])) else $error("safe rose");
	AST_LIMP_CAUSE: assert property ($fell(limp_home_output_n_o) |->
		$past(fault_i) != 8'h00 || failsafe_o) else $error("limp fell");
	AST_OV_FS: assert property (s_ov_held |-> ##[0:3] failsafe_o)
		else $error("overvoltage did not enter fail-safe");
endmodule // sfm_fault_mgr_chk

bind sfm_fault_mgr sfm_fault_mgr_chk #(.FS_SHORT_CYC(FS_SHORT_CYC),
	.FS_LONG_CYC(FS_LONG_CYC)) u_chk (.*);

`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
	// ------
	// signals
	// ------
	logic ref_clk_i, sys_rst_i, reg_we_i, reg_re_i, powerup_done_i;
	logic [7:0] reg_addr_i, otp_rst_impact_i, fault_i;
	logic [31:0] reg_wdata_i, reg_rdata_o;
	logic otp_rst_low_fs_en_i, otp_ov_fs_en_i, otp_tsd_fs_en_i;
	logic otp_first_fault_fs_i, failsafe_duration_option_i;
	logic failsafe_to_sleep_option_i, key_cycle_option_i, wake_i;
	logic low_power_on_req_i, low_power_off_req_i, ext_reset_det_i;
	logic regulator_overvoltage_i, regulator_thermal_shutdown_i;
	logic main_supply_lowpower_uv_i, mcu_reset_fb_n_i, hold_low, ext_rst;
	logic mcu_reset_output_n_o, safe_state_output_n_o, limp_home_output_n_o;
	logic regulator_en_o, osc_20mhz_en_o, monitor_en_o, failsafe_o;
	int failures, checks_done, c;

	sfm_fault_mgr #(.FS_SHORT_CYC(20), .FS_LONG_CYC(40), .RST_LOW_CYC(50))
		dut (.*);
	sfm_mcu_model u_mcu (.rst_n_i(mcu_reset_output_n_o),
		.hold_low_i(hold_low), .ext_rst_i(ext_rst),
		.fb_n_o(mcu_reset_fb_n_i), .ext_det_o(ext_reset_det_i));

	// ------
	// tasks
	// ------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_we_i <= 1'b0;
		#1;
	endtask

	task automatic rc(string nm, logic [7:0] a, logic [31:0] e,
		logic [31:0] mk = 32'hffffffff);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_re_i <= 1'b0;
		#1;
		chk(nm, e, reg_rdata_o & mk);
	endtask

	task automatic rs(int l, sfm_pkg::sfm_mode_e m, int n);
		rc("status", sfm_pkg::ADDR_STATUS, {21'h0, 4'(l), 3'(m), 4'(n)});
	endtask

	function automatic logic [31:0] pins();
		return {29'h0, mcu_reset_output_n_o, safe_state_output_n_o,
			limp_home_output_n_o};
	endfunction

	// 0 power-up done, 1 low-power-on request, 2 wake
	task automatic strobe(int k);
		@(posedge ref_clk_i);
		powerup_done_i <= (k == 0);
		low_power_on_req_i <= (k == 1);
		wake_i <= (k == 2);
		@(posedge ref_clk_i);
		{powerup_done_i, low_power_on_req_i, wake_i} <= 3'b000;
		#1;
	endtask

	task automatic flt(logic [7:0] b);
		@(posedge ref_clk_i);
		fault_i <= b;
		@(posedge ref_clk_i);
		fault_i <= 8'h00;
		@(posedge ref_clk_i);
		#1;
	endtask

	task automatic wfs(logic e, int n);
		c = 0;
		checks_done++;
		while (failsafe_o !== e && c < n) begin
			@(posedge ref_clk_i);
			#1;
			c++;
		end
		if (failsafe_o !== e) begin
			failures++;
			$display("MISMATCH failsafe_o expected %b seen %b", e, failsafe_o);
			stop_test();
		end
	endtask

	// ------
	// stimulus
	// ------
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	initial begin
		{sys_rst_i, reg_we_i, reg_re_i, powerup_done_i, wake_i} = 5'b10000;
		{otp_rst_low_fs_en_i, otp_ov_fs_en_i, otp_tsd_fs_en_i} = 3'b000;
		{otp_first_fault_fs_i, failsafe_duration_option_i} = 2'b00;
		{failsafe_to_sleep_option_i, key_cycle_option_i} = 2'b00;
		{low_power_on_req_i, low_power_off_req_i, hold_low, ext_rst} = 4'h0;
		{regulator_overvoltage_i, regulator_thermal_shutdown_i} = 2'b00;
		main_supply_lowpower_uv_i = 1'b0;
		{reg_addr_i, reg_wdata_i, fault_i} = 48'h0;
		otp_rst_impact_i = 8'h01;
		repeat (3) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		#1;
		chk("pins", 32'h1, pins());
		rs(6, sfm_pkg::MODE_POWERUP, 1);
		strobe(0);
		wr(sfm_pkg::ADDR_CFG, 32'h2);
		wr(sfm_pkg::ADDR_SAFE_IMPACT, 32'h7f);
		wr(sfm_pkg::ADDR_LIMP_IMPACT, 32'h2);
		wr(sfm_pkg::ADDR_CFG, 32'ha);
		wr(sfm_pkg::ADDR_RELEASE, 32'h7);
		chk("pins", 32'h7, pins());
		wr(sfm_pkg::ADDR_SAFE_IMPACT, 32'h0);
		rc("safe impact", sfm_pkg::ADDR_SAFE_IMPACT, 32'h7f);
		flt(8'h80);
		rc("flags", sfm_pkg::ADDR_FLAGS, 32'h80, 32'h1ff);
		rs(8, sfm_pkg::MODE_NORMAL, 1);
		@(posedge ref_clk_i) ext_rst <= 1'b1;
		repeat (8) @(posedge ref_clk_i);
		ext_rst <= 1'b0;
		repeat (6) @(posedge ref_clk_i);
		#1;
		chk("pins", 32'h7, pins());
		rs(8, sfm_pkg::MODE_NORMAL, 2);
		flt(8'h02);
		chk("pins", 32'h4, pins());
		rs(8, sfm_pkg::MODE_NORMAL, 3);
		repeat (4) flt(8'h02);
		rs(8, sfm_pkg::MODE_NORMAL, 7);
		flt(8'h02);
		chk("failsafe", 32'h1, 32'(failsafe_o));
		rs(8, sfm_pkg::MODE_FAILSAFE, 1);
		rc("flags", sfm_pkg::ADDR_FLAGS, 32'h100, 32'h100);
		wfs(1'b0, 30);
		rs(8, sfm_pkg::MODE_POWERUP, 1);
		$display("test counting done");
		strobe(0);
		@(posedge ref_clk_i);
		{otp_first_fault_fs_i, failsafe_duration_option_i} <= 2'b11;
		key_cycle_option_i <= 1'b1;
		wr(sfm_pkg::ADDR_CFG, 32'h3);
		rs(12, sfm_pkg::MODE_INIT, 1);
		flt(8'h01);
		chk("failsafe", 32'h1, 32'(failsafe_o));
		wfs(1'b0, 60);
		chk("long dwell", 32'h1, 32'(c >= 39 && c <= 42));
		rs(12, sfm_pkg::MODE_LOW_POWER_OFF_MODE, 1);
		@(posedge ref_clk_i);
		{otp_first_fault_fs_i, failsafe_duration_option_i} <= 2'b00;
		key_cycle_option_i <= 1'b0;
		strobe(2);
		$display("test first fault done");
		strobe(0);
		wr(sfm_pkg::ADDR_CFG, 32'hb);
		strobe(1);
		rs(12, sfm_pkg::MODE_LOW_POWER_ON_MODE, 1);
		chk("supply", 32'h4, {29'h0, regulator_en_o, osc_20mhz_en_o,
			monitor_en_o});
		@(posedge ref_clk_i) main_supply_lowpower_uv_i <= 1'b1;
		wfs(1'b1, 10);
		@(posedge ref_clk_i) main_supply_lowpower_uv_i <= 1'b0;
		wfs(1'b0, 30);
		for (int k = 0; k < 2; k++) begin
			@(posedge ref_clk_i);
			{otp_ov_fs_en_i, regulator_overvoltage_i} <= {2{k == 0}};
			{otp_tsd_fs_en_i, regulator_thermal_shutdown_i} <= {2{k == 1}};
			wfs(1'b1, 10);
			@(posedge ref_clk_i);
			{regulator_overvoltage_i, regulator_thermal_shutdown_i} <= 2'b00;
			wfs(1'b0, 30);
		end
		strobe(0);
		wr(sfm_pkg::ADDR_CFG, 32'hf);
		wr(sfm_pkg::ADDR_RELEASE, 32'h3);
		@(posedge ref_clk_i) ext_rst <= 1'b1;
		repeat (8) @(posedge ref_clk_i);
		ext_rst <= 1'b0;
		repeat (6) @(posedge ref_clk_i);
		#1;
		rc("release", sfm_pkg::ADDR_RELEASE, 32'h1);
		rs(12, sfm_pkg::MODE_NORMAL, 2);
		repeat (6) @(posedge ref_clk_i);
		otp_rst_low_fs_en_i <= 1'b1;
		hold_low <= 1'b1;
		wfs(1'b1, 70);
		chk("low time", 32'h1, 32'(c >= 50 && c <= 58));
		@(posedge ref_clk_i);
		{otp_rst_low_fs_en_i, hold_low} <= 2'b00;
		wfs(1'b0, 30);
		$display("test fail-safe causes done");
		strobe(0);
		wr(sfm_pkg::ADDR_CFG, 32'h8);
		@(posedge ref_clk_i);
		low_power_on_req_i <= 1'b1;
		low_power_off_req_i <= 1'b1;
		@(posedge ref_clk_i);
		low_power_on_req_i <= 1'b0;
		low_power_off_req_i <= 1'b0;
		@(posedge ref_clk_i);
		#1;
		chk("supply", 32'h0, {29'h0, regulator_en_o, osc_20mhz_en_o,
			monitor_en_o});
		chk("pins", 32'h0, pins());
		rs(2, sfm_pkg::MODE_LOW_POWER_OFF_MODE, 1);
		$display("test low power done");
		stop_test();
	end
endmodule // testbench

`default_nettype wire
